// [canpdo_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module canpdo_master_model (
  input  wire logic       clk,      // system clock
  input  wire logic       rst_n,    // reset
  input  wire logic       sync_go,  // bench asks for a sync frame
  input  wire logic [2:0] rtr_go,   // bench asks for remote frames
  output logic            sync_rx,  // sync frame seen by node
  output logic      [2:0] rtr_rx    // remote frames seen by node
);
  // frames land one cycle after the command and last as long as the command is held
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_rx <= 1'b0;
      rtr_rx  <= 3'h0;
    end
    else
    begin
      sync_rx <= sync_go;
      rtr_rx  <= rtr_go;
    end
  end
endmodule
`default_nettype wire

// [canpdo_node.sv]
// What this block does
// - type 0: event pending, send on next sync
// - event is value change or timer expiry
// - types 1-240: send every N syncs
// - types 252/253 reply to remote requests
// - 252 samples at sync, 253 at request
// - types 254/255 send on change or timer
// - nonzero event timer repeats sends periodically
// - inhibit time blocks event sends until elapsed
// - inhibit in 100 us, timer in 1 ms
// - node value is tens*10 plus units
// - values 1-98 become the node number
// - switch value 0 maps to node 1
// - value 99 at power-up enters selection
// - selection: network LED blinks green, 500 ms; module LED too while red shows
// - units 0: red blinks stored code, pause
// - codes 1-9 map to fixed bit rates
// - units 1-9 is the candidate code
// - candidate shown by green count blinks
// - tens to 0 confirms and stores code
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module canpdo_node #(
  parameter int TICK_CYCLES = canpdo_pkg::TICK_CYCLES // 100 us tick
) (
  input  wire logic        CLOCK,                      // 125 MHz clock
  input  wire logic        NRST,                       // async reset
  input  wire logic        CE,                         // clock enable
  input  wire logic        HSEL,                       // slave select
  input  wire logic [31:0] HADDR,                      // address
  input  wire logic [1:0]  HTRANS,                     // transfer type
  input  wire logic        HWRITE,                     // write
  input  wire logic [2:0]  HSIZE,                      // size
  input  wire logic [31:0] HWDATA,                     // write data
  input  wire logic        HREADY,                     // bus ready
  output logic      [31:0] HRDATA,                     // read data
  output logic             HREADYOUT,                  // slave ready
  output logic             HRESP,                      // always okay
  input  wire logic        SYNC_RX,                    // sync received
  input  wire logic [2:0]  RTR_RX,                     // request per object
  input  wire logic [2:0]  VALUE_CHANGED,              // change per object
  output logic      [2:0]  TX_REQ,                     // send pulses
  output logic      [2:0]  SAMPLE_REQ,                 // snapshot pulses
  input  wire logic [3:0]  TENS_ROTARY_SWITCH,         // tens digit
  input  wire logic [3:0]  UNITS_ROTARY_SWITCH,        // units digit
  input  wire logic [3:0]  NV_RATE_CODE,               // stored rate code
  output logic             NV_WRITE,                   // store pulse
  output logic      [3:0]  NV_WRITE_CODE,              // code to store
  output logic      [6:0]  NODE_NUMBER,                // node in use
  output logic      [3:0]  RATE_CODE,                  // rate in use
  output logic             SELECT_MODE,                // selection active
  output logic             MODULE_STATUS_LED_GREEN,    // module led green
  output logic             MODULE_STATUS_LED_RED,      // module led red
  output logic             NETWORK_STATUS_LED_GREEN,   // network led green
  output logic             NETWORK_STATUS_LED_RED      // network led red
);

  localparam int NP = canpdo_pkg::NUM_PDO;

  logic [1:0]  rst_sync_reg;
  logic        rst_n;
  logic [13:0] tick_cnt_reg;
  logic [3:0]  ms_div_reg;
  logic        tick_100us;
  logic        tick_1ms;
  logic [7:0]  type_reg [NP];
  logic [15:0] inh_reg [NP];
  logic [15:0] evt_reg [NP];
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic        addr_ok;
  logic [31:0] rd_next;
  logic        started_reg;
  logic        confirmed_reg;
  logic        tens_zero_reg;
  logic [6:0]  sw_value;
  logic [3:0]  store_rate_reg;
  logic [9:0]  sel_ms_reg;
  logic        sel_phase_reg;
  logic        confirm;
  logic        show_red;
  logic [3:0]  show_code;
  logic [3:0]  shown_reg;
  logic [3:0]  blink_n_reg;
  logic [9:0]  ph_ms_reg;
  logic        pat_on;
  canpdo_pkg::blink_state_t bl_state_reg;

  // ==========================================================
  // reset release through two flops
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // ==========================================================
  // time base: 100 us ticks, every tenth is a 1 ms tick
  assign tick_100us = CE && (tick_cnt_reg == 14'(TICK_CYCLES - 1));
  assign tick_1ms   = tick_100us && (ms_div_reg == 4'(canpdo_pkg::TICKS_PER_MS - 1));

  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt_reg <= 14'h0000;
      ms_div_reg   <= 4'h0;
    end
    else if (CE)
    begin
      tick_cnt_reg <= tick_100us ? 14'h0000 : tick_cnt_reg + 14'h0001;
      if (tick_1ms)
        ms_div_reg <= 4'h0;
      else if (tick_100us)
        ms_div_reg <= ms_div_reg + 4'h1;
    end
  end

  // ==========================================================
  // bus slave: zero wait states, reads captured in address phase
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign addr_ok   = HSEL && HTRANS[1] && HREADY;

  always_comb
  begin
    rd_next = 32'h0000_0000;
    if (HADDR[7:0] == canpdo_pkg::A_STATUS)
    begin
      rd_next[canpdo_pkg::ST_NODE_LSB +: 7] = NODE_NUMBER;
      rd_next[canpdo_pkg::ST_SEL_BIT]  = SELECT_MODE;
      rd_next[canpdo_pkg::ST_CONF_BIT] = confirmed_reg;
      rd_next[canpdo_pkg::ST_ACT_LSB +: 4]   = RATE_CODE;
      rd_next[canpdo_pkg::ST_STORE_LSB +: 4] = store_rate_reg;
    end
    for (int i = 0; i < NP; i++)
    begin
      if (HADDR[7:0] == 8'(canpdo_pkg::A_PDO_BASE + i * canpdo_pkg::A_PDO_STRIDE))
        rd_next[7:0] = type_reg[i];
      if (HADDR[7:0] == 8'(canpdo_pkg::A_PDO_BASE + i * canpdo_pkg::A_PDO_STRIDE
                           + canpdo_pkg::A_TIME_OFS))
        rd_next = {evt_reg[i], inh_reg[i]};
    end
    if (HADDR[31:8] != 24'h000000)
      rd_next = 32'h0000_0000;
  end

  // address phase capture
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      HRDATA      <= 32'h0000_0000;
    end
    else if (CE && HREADY)
    begin
      wr_pend_reg <= addr_ok && HWRITE && (HADDR[31:8] == 24'h000000);
      wr_addr_reg <= HADDR[7:0];
      if (addr_ok && !HWRITE)
        HRDATA <= rd_next;
    end
  end

  // per-object configuration and trigger units
  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_pdo
      localparam logic [7:0] CFG_A = 8'(canpdo_pkg::A_PDO_BASE + g * canpdo_pkg::A_PDO_STRIDE);
      localparam logic [7:0] TIM_A = 8'(CFG_A + canpdo_pkg::A_TIME_OFS);

      always_ff @(posedge CLOCK or negedge rst_n)
      begin
        if (!rst_n)
        begin
          type_reg[g] <= canpdo_pkg::TYPE_RST;
          inh_reg[g]  <= canpdo_pkg::INHIBIT_RST;
          evt_reg[g]  <= canpdo_pkg::EVTIME_RST;
        end
        else if (CE && wr_pend_reg)
        begin
          if (wr_addr_reg == CFG_A)
            type_reg[g] <= HWDATA[7:0];
          if (wr_addr_reg == TIM_A)
          begin
            inh_reg[g] <= HWDATA[canpdo_pkg::TM_INH_LSB +: 16];
            evt_reg[g] <= HWDATA[canpdo_pkg::TM_EVT_LSB +: 16];
          end
        end
      end

      pdo_trigger u_trig (
        .clk           (CLOCK),
        .rst_n         (rst_n),
        .ce            (CE),
        .tick_100us    (tick_100us),
        .tick_1ms      (tick_1ms),
        .sync_rx       (SYNC_RX),
        .rtr_rx        (RTR_RX[g]),
        .value_changed (VALUE_CHANGED[g]),
        .tx_type       (type_reg[g]),
        .inhibit       (inh_reg[g]),
        .event_time    (evt_reg[g]),
        .tx_req        (TX_REQ[g]),
        .sample_req    (SAMPLE_REQ[g])
      );
    end
  endgenerate

  // ==========================================================
  // switch reading, latched once after reset release
  // widen before the product: a 4-bit product would wrap above 15
  assign sw_value = 7'(TENS_ROTARY_SWITCH) * 7'h0a + 7'(UNITS_ROTARY_SWITCH);

  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      started_reg    <= 1'b0;
      NODE_NUMBER    <= canpdo_pkg::NODE_MIN;
      SELECT_MODE    <= 1'b0;
      RATE_CODE      <= canpdo_pkg::RATE_MIN;
      store_rate_reg <= canpdo_pkg::RATE_MIN;
    end
    else if (CE)
    begin
      if (!started_reg)
      begin
        started_reg    <= 1'b1;
        SELECT_MODE    <= (sw_value == canpdo_pkg::SW_SEL_MODE);
        RATE_CODE      <= NV_RATE_CODE;
        store_rate_reg <= NV_RATE_CODE;
        if (sw_value == 7'h00)
          NODE_NUMBER <= canpdo_pkg::NODE_MIN;
        else
          NODE_NUMBER <= sw_value;
      end
      else if (confirm)
        store_rate_reg <= UNITS_ROTARY_SWITCH;
    end
  end

  // confirm on tens reaching 0 with a candidate set
  assign confirm = SELECT_MODE && (TENS_ROTARY_SWITCH == 4'h0) && !tens_zero_reg
                   && (UNITS_ROTARY_SWITCH >= canpdo_pkg::RATE_MIN)
                   && (UNITS_ROTARY_SWITCH <= canpdo_pkg::RATE_MAX);

  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tens_zero_reg <= 1'b1;
      confirmed_reg <= 1'b0;
      NV_WRITE      <= 1'b0;
      NV_WRITE_CODE <= 4'h0;
    end
    else if (CE)
    begin
      tens_zero_reg <= !started_reg || (TENS_ROTARY_SWITCH == 4'h0);
      NV_WRITE      <= confirm;
      if (confirm)
      begin
        confirmed_reg <= 1'b1;
        NV_WRITE_CODE <= UNITS_ROTARY_SWITCH;
      end
      else if (TENS_ROTARY_SWITCH != 4'h0)
        confirmed_reg <= 1'b0;
    end
  end

  // ==========================================================
  // 500 ms green blink for selection mode
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_ms_reg    <= 10'h000;
      sel_phase_reg <= 1'b0;
    end
    else if (CE && tick_1ms)
    begin
      if (sel_ms_reg == 10'(canpdo_pkg::SEL_HALF_MS - 1))
      begin
        sel_ms_reg    <= 10'h000;
        sel_phase_reg <= !sel_phase_reg;
      end
      else
        sel_ms_reg <= sel_ms_reg + 10'h001;
    end
  end

  // count pattern: code blinks, then a long dark pause
  assign show_red  = (UNITS_ROTARY_SWITCH == 4'h0) || confirmed_reg;
  assign show_code = show_red ? store_rate_reg : UNITS_ROTARY_SWITCH;
  assign pat_on    = (bl_state_reg == canpdo_pkg::BL_ON);

  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bl_state_reg <= canpdo_pkg::BL_ON;
      blink_n_reg  <= 4'h0;
      ph_ms_reg    <= 10'h000;
      shown_reg    <= 4'h0;
    end
    else if (CE)
    begin
      shown_reg <= show_code;
      if (shown_reg != show_code)
      begin
        bl_state_reg <= canpdo_pkg::BL_ON; // restart on a new code
        blink_n_reg  <= 4'h0;
        ph_ms_reg    <= 10'h000;
      end
      else if (tick_1ms)
      begin
        ph_ms_reg <= ph_ms_reg + 10'h001;
        case (bl_state_reg)
          canpdo_pkg::BL_ON:
            if (ph_ms_reg >= 10'(canpdo_pkg::CODE_ON_MS - 1))
            begin
              ph_ms_reg   <= 10'h000;
              blink_n_reg <= blink_n_reg + 4'h1;
              if (blink_n_reg + 4'h1 >= show_code)
                bl_state_reg <= canpdo_pkg::BL_PAUSE;
              else
                bl_state_reg <= canpdo_pkg::BL_OFF;
            end
          canpdo_pkg::BL_OFF:
            if (ph_ms_reg >= 10'(canpdo_pkg::CODE_OFF_MS - 1))
            begin
              ph_ms_reg    <= 10'h000;
              bl_state_reg <= canpdo_pkg::BL_ON;
            end
          canpdo_pkg::BL_PAUSE:
            if (ph_ms_reg >= 10'(canpdo_pkg::CODE_PAUSE_MS - 1))
            begin
              ph_ms_reg    <= 10'h000;
              blink_n_reg  <= 4'h0;
              bl_state_reg <= canpdo_pkg::BL_ON;
            end
          default:
            bl_state_reg <= canpdo_pkg::BL_ON;
        endcase
      end
    end
  end

  // ==========================================================
  // led drive: dark outside selection mode (normal patterns live elsewhere)
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      MODULE_STATUS_LED_GREEN  <= 1'b0;
      MODULE_STATUS_LED_RED    <= 1'b0;
      NETWORK_STATUS_LED_GREEN <= 1'b0;
      NETWORK_STATUS_LED_RED   <= 1'b0;
    end
    else if (CE)
    begin
      NETWORK_STATUS_LED_GREEN <= SELECT_MODE && sel_phase_reg;
      MODULE_STATUS_LED_GREEN  <= SELECT_MODE && (show_red ? sel_phase_reg : pat_on);
      MODULE_STATUS_LED_RED    <= SELECT_MODE && show_red && pat_on;
      NETWORK_STATUS_LED_RED   <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [canpdo_node_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module canpdo_node_checker (
  input wire logic        CLOCK,                  // system clock
  input wire logic        NRST,                   // async reset
  input wire logic        CE,                     // clock enable
  input wire logic        HSEL,                   // slave select
  input wire logic [1:0]  HTRANS,                 // transfer type
  input wire logic        HWRITE,                 // write
  input wire logic        HREADY,                 // bus ready
  input wire logic [31:0] HRDATA,                 // read data
  input wire logic        HREADYOUT,              // slave ready
  input wire logic        HRESP,                  // response
  input wire logic        NV_WRITE,               // store pulse
  input wire logic [3:0]  NV_WRITE_CODE,          // code to store
  input wire logic [6:0]  NODE_NUMBER,            // node in use
  input wire logic [3:0]  RATE_CODE,              // rate in use
  input wire logic        SELECT_MODE,            // selection active
  input wire logic        NETWORK_STATUS_LED_RED  // network led red
);
  // ==========================================================
  // checks on the one clock; reset ends every check
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);

  chk_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready or not okay");
  // read data only moves after a read address phase was taken
  chk_rdata_hold: assert property (!$past(HSEL && HTRANS[1] && HREADY && CE && !HWRITE)
    |-> $stable(HRDATA)) else $error("read data moved without a read");
  chk_node_range: assert property (!SELECT_MODE |-> NODE_NUMBER inside {[1:98]})
    else $error("node number out of range");
  chk_sel_node: assert property (SELECT_MODE |-> NODE_NUMBER == 7'h63)
    else $error("selection mode without switch value 99");
  chk_sel_green: assert property (SELECT_MODE |-> !NETWORK_STATUS_LED_RED)
    else $error("network led red during selection");
  chk_rate_range: assert property (RATE_CODE inside {[1:9]})
    else $error("rate code out of range");
  chk_rate_hold: assert property ($past(SELECT_MODE) && SELECT_MODE |-> $stable(RATE_CODE))
    else $error("rate in use changed before reset");
  chk_nv_pulse: assert property (NV_WRITE |=> !NV_WRITE)
    else $error("store pulse longer than one cycle");
  chk_nv_code: assert property (NV_WRITE |-> SELECT_MODE && NV_WRITE_CODE inside {[1:9]})
    else $error("bad store request");
  chk_mode_latch: assert property (SELECT_MODE |=> SELECT_MODE)
    else $error("selection mode left without reset");
endmodule
`default_nettype wire

// [canpdo_pkg.sv]
package canpdo_pkg;

  // ==========================================================
  // register map (byte addresses, one word each)
  localparam logic [7:0] A_STATUS     = 8'h00; // node, mode, rates
  localparam logic [7:0] A_PDO_BASE   = 8'h10; // first transmit object
  localparam logic [7:0] A_PDO_STRIDE = 8'h08; // two words per object
  localparam logic [7:0] A_TIME_OFS   = 8'h04; // timing word offset
  localparam int         NUM_PDO      = 3;

  // field positions
  localparam int ST_NODE_LSB  = 0;
  localparam int ST_SEL_BIT   = 8;
  localparam int ST_CONF_BIT  = 9;
  localparam int ST_ACT_LSB   = 16;
  localparam int ST_STORE_LSB = 20;
  localparam int TM_INH_LSB   = 0;
  localparam int TM_EVT_LSB   = 16;

  // reset values
  localparam logic [7:0]  TYPE_RST    = 8'hff;
  localparam logic [15:0] INHIBIT_RST = 16'h0000;
  localparam logic [15:0] EVTIME_RST  = 16'h0000;

  // transmission types
  localparam logic [7:0] TT_SYNC_EVT  = 8'h00;
  localparam logic [7:0] TT_CYC_MIN   = 8'h01;
  localparam logic [7:0] TT_CYC_MAX   = 8'hf0;
  localparam logic [7:0] TT_RTR_SYNC  = 8'hfc;
  localparam logic [7:0] TT_RTR_ASYNC = 8'hfd;
  localparam logic [7:0] TT_ASYNC_MIN = 8'hfe;

  // switches and bit-rate codes
  localparam logic [6:0] SW_SEL_MODE = 7'h63; // both digits at nine
  localparam logic [6:0] NODE_MIN    = 7'h01;
  localparam logic [3:0] DIGIT_MAX   = 4'h9;
  localparam logic [3:0] RATE_MIN    = 4'h1;
  localparam logic [3:0] RATE_MAX    = 4'h9;

  // ==========================================================
  // timing
  localparam int CLK_MHZ        = 125;
  localparam int INH_UNIT_US    = 100;
  localparam int EVT_UNIT_US    = 1000;
  localparam int TICK_CYCLES    = INH_UNIT_US * CLK_MHZ;
  localparam int TICKS_PER_MS   = EVT_UNIT_US / INH_UNIT_US;
  localparam int SEL_PERIOD_MS  = 500;
  localparam int SEL_HALF_MS    = SEL_PERIOD_MS / 2;
  localparam int CODE_ON_MS     = 200;
  localparam int CODE_OFF_MS    = 200;
  localparam int CODE_PAUSE_MS  = 1000;

  typedef enum logic [1:0] {BL_ON, BL_OFF, BL_PAUSE} blink_state_t;

endpackage

// [pdo_trigger.sv]
`timescale 1ns/1ps
`default_nettype none
module pdo_trigger (
  input  wire logic        clk,           // system clock
  input  wire logic        rst_n,         // synchronised reset
  input  wire logic        ce,            // clock enable
  input  wire logic        tick_100us,    // inhibit time base
  input  wire logic        tick_1ms,      // event timer base
  input  wire logic        sync_rx,       // sync message seen
  input  wire logic        rtr_rx,        // remote request seen
  input  wire logic        value_changed, // mapped variable changed
  input  wire logic [7:0]  tx_type,       // transmission type
  input  wire logic [15:0] inhibit,       // in 100 us units
  input  wire logic [15:0] event_time,    // in 1 ms units
  output logic             tx_req,        // send the object
  output logic             sample_req     // snapshot mapped variables
);

  logic [7:0]  sync_cnt_reg;
  logic [15:0] evt_cnt_reg;
  logic [15:0] inh_reg;
  logic        pend_reg;
  logic        is_cyc;
  logic        is_async;
  logic        expiry;
  logic        event_hit;
  logic        send;
  logic        sample;

  // ==========================================================
  // trigger decode
  assign is_cyc    = (tx_type >= canpdo_pkg::TT_CYC_MIN) && (tx_type <= canpdo_pkg::TT_CYC_MAX);
  assign is_async  = tx_type >= canpdo_pkg::TT_ASYNC_MIN;
  assign expiry    = (event_time != 16'h0000) && tick_1ms
                     && ((evt_cnt_reg + 16'h0001) >= event_time);
  assign event_hit = value_changed | expiry;

  // types 241..251 match no term, so they never send
  always_comb
  begin
    send   = 1'b0;
    sample = 1'b0;
    if (tx_type == canpdo_pkg::TT_SYNC_EVT)
      send = sync_rx && (pend_reg || event_hit);
    else if (is_cyc)
      send = sync_rx && ((sync_cnt_reg + 8'h01) >= tx_type);
    else if (tx_type == canpdo_pkg::TT_RTR_SYNC)
      send = rtr_rx;
    else if (tx_type == canpdo_pkg::TT_RTR_ASYNC)
      send = rtr_rx;
    else if (is_async)
      send = (event_hit || pend_reg) && (inh_reg == 16'h0000);
    if (tx_type == canpdo_pkg::TT_RTR_SYNC)
      sample = sync_rx;
    else
      sample = send;
  end

  // cyclic sync counter, restarts after each send
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sync_cnt_reg <= 8'h00;
    else if (ce)
    begin
      if (!is_cyc || send)
        sync_cnt_reg <= 8'h00;
      else if (sync_rx)
        sync_cnt_reg <= sync_cnt_reg + 8'h01;
    end
  end

  // pending event, held until sync or inhibit end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pend_reg <= 1'b0;
    else if (ce)
    begin
      if (send || !(is_async || tx_type == canpdo_pkg::TT_SYNC_EVT))
        pend_reg <= 1'b0;
      else if (event_hit)
        pend_reg <= 1'b1;
    end
  end

  // event timer restarts on every send so it only fills quiet gaps
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      evt_cnt_reg <= 16'h0000;
    else if (ce)
    begin
      if (event_time == 16'h0000 || expiry || send)
        evt_cnt_reg <= 16'h0000;
      else if (tick_1ms)
        evt_cnt_reg <= evt_cnt_reg + 16'h0001;
    end
  end

  // inhibit window after an event-driven send
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      inh_reg <= 16'h0000;
    else if (ce)
    begin
      if (send && is_async)
        inh_reg <= inhibit;
      else if (tick_100us && inh_reg != 16'h0000)
        inh_reg <= inh_reg - 16'h0001;
    end
  end

  // registered requests
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_req     <= 1'b0;
      sample_req <= 1'b0;
    end
    else if (ce)
    begin
      tx_req     <= send;
      sample_req <= sample;
    end
  end

endmodule
`default_nettype wire

// [tb_canpdo_node.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_canpdo_node;
  typedef struct {logic [7:0] ty; logic [4:0] f;} row_t; // f: sync rtr chg tx sample
  logic        clk, nrst, hsel, hwr, hrdy, hresp, sync_go, sync_rx;
  logic        nvw, sel, msg, msr, nsg, nsr, m, ce = 1'b1;
  logic [1:0]  htr;
  logic [2:0]  rtr_go, rtr_rx, chg, txq, smq;
  logic [3:0]  tens, units, nvc, nvwc, rate;
  logic [6:0]  node;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          mismatches = 0, tests_run = 0, n, j;
  logic [7:0]  sw [3] = '{8'h00, 8'h98, 8'h57};
  logic [6:0]  nd [3] = '{7'h01, 7'h62, 7'h39};
  row_t        rows [11] = '{'{8'h00, 5'h10}, '{8'h00, 5'h17}, '{8'h01, 5'h13},
    '{8'hfc, 5'h11}, '{8'hfc, 5'h0a}, '{8'hfd, 5'h0b}, '{8'hfd, 5'h10}, '{8'hfe, 5'h07},
    '{8'hff, 5'h07}, '{8'hf5, 5'h1c}, '{8'h01, 5'h08}};

  // ==========================================================
  // design, partner, clock; short tick keeps the run small
  canpdo_node #(.TICK_CYCLES(10)) i_dut (.CLOCK(clk), .NRST(nrst), .CE(ce), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htr), .HWRITE(hwr), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
    .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .SYNC_RX(sync_rx), .RTR_RX(rtr_rx),
    .VALUE_CHANGED(chg), .TX_REQ(txq), .SAMPLE_REQ(smq), .TENS_ROTARY_SWITCH(tens),
    .UNITS_ROTARY_SWITCH(units), .NV_RATE_CODE(nvc), .NV_WRITE(nvw), .NV_WRITE_CODE(nvwc),
    .NODE_NUMBER(node), .RATE_CODE(rate), .SELECT_MODE(sel), .MODULE_STATUS_LED_GREEN(msg),
    .MODULE_STATUS_LED_RED(msr), .NETWORK_STATUS_LED_GREEN(nsg), .NETWORK_STATUS_LED_RED(nsr));
  canpdo_master_model i_master (.clk(clk), .rst_n(nrst), .sync_go(sync_go), .rtr_go(rtr_go),
    .sync_rx(sync_rx), .rtr_rx(rtr_rx));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one whole-word transfer; the address phase is held until ready
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htr <= 2'h2;
    hwr <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htr <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  // value change waits a cycle to meet the partner's frames
  task pulse(input logic s, input logic [2:0] r, input logic [2:0] c);
    @(posedge clk);
    sync_go <= s;
    rtr_go <= r;
    @(posedge clk);
    sync_go <= 1'b0;
    rtr_go <= 3'h0;
    chg <= c;
    @(posedge clk);
    chg <= 3'h0;
    #1;
  endtask
  task wait_tx(input int k, input int lim);
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (txq[k] !== 1'b1 && n < lim);
  endtask
  task reset(input logic [3:0] t, input logic [3:0] u);
    @(posedge clk);
    nrst <= 1'b0;
    tens <= t;
    units <= u;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  initial
  begin
    {nrst, hsel, hwr, sync_go, htr, rtr_go, chg, tens, units, haddr, hwdata} = '0;
    nvc = 4'h4;
    for (int i = 0; i < 3; i++)
    begin
      reset(sw[i][7:4], sw[i][3:0]);
      bus(1'b0, 8'h00, 32'h0);
      check(rd[6:0], nd[i]);
      check(rd[19:16], nvc);
    end
    units <= 4'h1;
    bus(1'b0, 8'h20, 32'h0);
    check(rd[7:0], canpdo_pkg::TYPE_RST);
    bus(1'b0, 8'h24, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 8'hf0, 32'h0);
    check(rd, 32'h0);
    check(node, 7'h39);
    $display("switches done");
    foreach (rows[i])
    begin
      j = i % 3;
      bus(1'b1, 8'h10 + 8'(8 * j), {24'h0, rows[i].ty});
      pulse(rows[i].f[4], 3'(rows[i].f[3]) << j, 3'(rows[i].f[2]) << j);
      check(txq[j], rows[i].f[1]);
      check(smq[j], rows[i].f[0]);
      $display("row %0d done", i);
    end
    bus(1'b1, 8'h20, 32'h3);
    for (int k = 1; k <= 6; k++)
    begin
      pulse(1'b1, 3'h0, 3'h0);
      check(txq[2], k % 3 == 0);
    end
    $display("cyclic type done");
    bus(1'b1, 8'h14, 32'h2);
    bus(1'b1, 8'h10, 32'hfe);
    pulse(1'b0, 3'h0, 3'h1);
    check(txq[0], 1'b1);
    pulse(1'b0, 3'h0, 3'h1);
    check(txq[0], 1'b0);
    wait_tx(0, 40);
    check(n >= 6 && n <= 19, 1'b1);
    $display("inhibit done");
    bus(1'b1, 8'h1c, 32'h0001_0000);
    bus(1'b1, 8'h18, 32'hff);
    wait_tx(1, 250);
    wait_tx(1, 250);
    check(n >= 99 && n <= 101, 1'b1);
    ce <= 1'b0;
    repeat (150) @(posedge clk);
    check(txq[1], 1'b1);
    ce <= 1'b1;
    bus(1'b1, 8'h24, 32'h0001_0000);
    bus(1'b1, 8'h20, 32'h0);
    wait_tx(2, 250);
    check(n, 250);
    pulse(1'b1, 3'h0, 3'h0);
    check(txq[2], 1'b1);
    $display("event timer done");
    reset(4'h9, 4'h9);
    check(sel, 1'b1);
    check(node, 7'h63);
    units <= 4'h0;
    for (int k = 0; k < 2; k++)
    begin
      m = nsg;
      n = 0;
      while (nsg === m && n < 26000)
      begin
        @(posedge clk);
        #1;
        n++;
      end
    end
    check(n >= 24990 && n <= 25010, 1'b1);
    check(msg, nsg);
    check(msr, 1'b1);
    units <= 4'h3;
    repeat (20) @(posedge clk);
    check(msg, 1'b1);
    tens <= 4'h0;
    n = 0;
    while (nvw !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(nvw, 1'b1);
    check(nvwc, 4'h3);
    check(rate, 4'h4);
    bus(1'b0, 8'h00, 32'h0);
    check(rd[23:20], 4'h3);
    $display("selection done");
    give_verdict;
  end

  // a hang counts as a mismatch
  initial
  begin
    #600000;
    mismatches++;
    $display("[FAIL] %0t: watchdog expired", $time);
    give_verdict;
  end
endmodule

bind canpdo_node canpdo_node_checker i_chk (.CLOCK(CLOCK), .NRST(NRST), .CE(CE), .HSEL(HSEL),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .NV_WRITE(NV_WRITE), .NV_WRITE_CODE(NV_WRITE_CODE), .NODE_NUMBER(NODE_NUMBER),
  .RATE_CODE(RATE_CODE), .SELECT_MODE(SELECT_MODE),
  .NETWORK_STATUS_LED_RED(NETWORK_STATUS_LED_RED));
`default_nettype wire
